// File: rtl/pmc_acc_if.sv
// pmc_acc_if: toggle handshake between serial link domain and core domain
// assumes each side synchronises the other's toggles before use
`default_nettype none
interface pmc_acc_if;
  logic       req_tgl;
  logic       we;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic       stop_tgl;
  logic       ack_tgl;
  logic [7:0] rdata;
  logic [6:0] dev_addr;
  logic       i2c_en;
  modport link (output req_tgl, we, addr, wdata, stop_tgl,
                input  ack_tgl, rdata, dev_addr, i2c_en);
  modport core (input  req_tgl, we, addr, wdata, stop_tgl,
                output ack_tgl, rdata, dev_addr, i2c_en);
endinterface : pmc_acc_if
`default_nettype wire

// File: rtl/pmc_i2c_slave.sv
// pmc_i2c_slave: serial slave running on the link clock
// assumes the link clock is at least 10x faster than scl
`default_nettype none
module pmc_i2c_slave (
  // clock and reset
  input  wire logic link_clk_i,
  input  wire logic nrst_i,
  // serial pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  // core side
  pmc_acc_if.link   acc
);
  typedef enum logic [2:0] {PH_IDLE, PH_DEV, PH_REG, PH_WR, PH_RD} pmc_ph_t;
  typedef struct packed {
    logic [10:0] s1;
    logic [10:0] s2;
    logic        scl_p;
    logic        sda_p;
    logic        ack_p;
    pmc_ph_t     ph;
    logic [3:0]  cnt;
    logic        aslot;
    logic        oe;
    logic        nack;
    logic [7:0]  sh;
    logic [7:0]  tx;
    logic [7:0]  rbuf;
    logic [6:0]  ptr;
    logic        req_tgl;
    logic        we;
    logic [6:0]  addr;
    logic [7:0]  wdata;
    logic        stop_tgl;
  } pmc_lnk_t;

  pmc_lnk_t r;
  pmc_lnk_t next_r;
  logic     scl;
  logic     sda;
  logic     start;
  logic     stop;

  assign scl   = r.s2[10];
  assign sda   = r.s2[9];
  // repeated start restarts the frame without ending the transaction
  assign start = r.s2[7] & scl & r.scl_p & r.sda_p & ~sda;
  assign stop  = r.s2[7] & scl & r.scl_p & ~r.sda_p & sda;

  always_comb begin
    next_r       = r;
    next_r.s1    = {scl_i, sda_i, acc.ack_tgl, acc.i2c_en, acc.dev_addr};
    next_r.s2    = r.s1;
    next_r.scl_p = scl;
    next_r.sda_p = sda;
    next_r.ack_p = r.s2[8];
    if (r.s2[8] != r.ack_p) begin
      next_r.rbuf = acc.rdata;
    end
    if (start) begin
      next_r.ph    = PH_DEV;
      next_r.cnt   = 4'h0;
      next_r.aslot = 1'h0;
      next_r.oe    = 1'h0;
    end else if (stop) begin
      next_r.ph       = PH_IDLE;
      next_r.oe       = 1'h0;
      next_r.aslot    = 1'h0;
      next_r.stop_tgl = ~r.stop_tgl;
    end else if (r.ph != PH_IDLE && scl && !r.scl_p) begin
      if (r.aslot) begin
        next_r.nack = sda;
      end else if (r.cnt < 4'h8) begin
        next_r.sh  = {r.sh[6:0], sda};
        next_r.cnt = r.cnt + 4'h1;
      end
    end else if (r.ph != PH_IDLE && !scl && r.scl_p) begin
      if (r.aslot) begin
        next_r.aslot = 1'h0;
        next_r.oe    = 1'h0;
        next_r.cnt   = 4'h0;
        if (r.ph == PH_RD) begin
          if (r.nack) begin
            next_r.ph = PH_IDLE;
          end else begin
            next_r.tx  = r.rbuf;
            next_r.oe  = ~r.rbuf[7];
            next_r.ptr = r.ptr + 7'h01;
          end
        end
      end else if (r.cnt == 4'h8) begin
        next_r.aslot = 1'h1;
        unique case (r.ph)
          PH_IDLE: begin
          end
          PH_DEV: begin
            if (r.sh[7:1] == r.s2[6:0]) begin
              next_r.oe   = 1'h1;
              next_r.nack = 1'h0;
              if (r.sh[0]) begin
                next_r.ph      = PH_RD;
                next_r.req_tgl = ~r.req_tgl;
                next_r.we      = 1'h0;
                next_r.addr    = r.ptr;
              end else begin
                next_r.ph = PH_REG;
              end
            end else begin
              next_r.ph    = PH_IDLE;
              next_r.aslot = 1'h0;
            end
          end
          PH_REG: begin
            next_r.ptr = r.sh[6:0];
            next_r.oe  = 1'h1;
            next_r.ph  = PH_WR;
          end
          PH_WR: begin
            next_r.req_tgl = ~r.req_tgl;
            next_r.we      = 1'h1;
            next_r.addr    = r.ptr;
            next_r.wdata   = r.sh;
            next_r.ptr     = r.ptr + 7'h01;
            next_r.oe      = 1'h1;
          end
          PH_RD: begin
            next_r.oe      = 1'h0;
            next_r.req_tgl = ~r.req_tgl;
            next_r.we      = 1'h0;
            next_r.addr    = r.ptr;
          end
        endcase
      end else if (r.ph == PH_RD) begin
        next_r.tx = {r.tx[6:0], 1'h0};
        next_r.oe = ~r.tx[6];
      end
    end
  end

  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sda_o        = 1'h0;
  assign sda_oe_o     = r.oe;
  assign acc.req_tgl  = r.req_tgl;
  assign acc.we       = r.we;
  assign acc.addr     = r.addr;
  assign acc.wdata    = r.wdata;
  assign acc.stop_tgl = r.stop_tgl;
endmodule : pmc_i2c_slave
`default_nettype wire

// File: rtl/pmc_pkg.sv
// pmc_pkg: shared constants of the power controller register block
// assumes a 7-bit register address space with byte wide registers
`default_nettype none
package pmc_pkg;
  localparam logic [6:0] ADR_LTS_CFG = 7'h06;
  localparam logic [6:0] ADR_CFG_END = 7'h18;
  localparam logic [6:0] ADR_PWR_MGT = 7'h19;
  localparam logic [6:0] ADR_SRST    = 7'h1a;
  localparam logic [6:0] ADR_KEY     = 7'h1b;
  localparam logic [6:0] ADR_LM_CTL  = 7'h1c;
  localparam logic [6:0] ADR_LM_OUT  = 7'h1d;
  localparam logic [6:0] ADR_NVM     = 7'h40;
  localparam logic [7:0] KEY_SRST    = 8'he2;
  localparam logic [7:0] KEY_CFG     = 8'h4b;
  localparam logic [7:0] KEY_NVM     = 8'ha5;
  localparam logic [7:0] SRST_WORD   = 8'hab;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam int         CFG_BYTES   = 26;
  localparam int         POS_FORCE   = 7;
  localparam int         POS_NO_PROT = 0;
  localparam int         POS_PRIM    = 1;
  localparam int         POS_PRIM_CN = 2;
  localparam int         POS_MEAS    = 6;
  localparam int         POS_RNG     = 5;
  localparam int         POS_MANU    = 4;
  localparam int         SETTLE_MS   = 2;
  localparam int         CLK_HZ      = 100_000_000;
  localparam int         SETTLE_CYC  = SETTLE_MS * (CLK_HZ / 1000);
endpackage : pmc_pkg
`default_nettype wire

// File: rtl/pmc_regs.sv
// pmc_regs: control registers, key protection, light meter and boot logic
// assumes status pins are asynchronous and the meter controller is on mclk_i
`default_nettype none
module pmc_regs #(
  parameter int SETTLE_CYC = pmc_pkg::SETTLE_CYC
) (
  // clocks and reset
  input  wire logic                         mclk_i,
  input  wire logic                         link_clk_i,
  input  wire logic                         nrst_i,
  // serial pins
  input  wire logic                         scl_i,
  input  wire logic                         sda_i,
  output logic                              sda_o,
  output logic                              sda_oe_o,
  input  wire logic                         cs_i,
  // analog status pins
  input  wire logic                         harvest_dis_i,
  input  wire logic                         sts_low_i,
  input  wire logic                         storage_low_limit_i,
  input  wire logic                         storage_disc_i,
  input  wire logic                         por_i,
  // non-volatile memory
  input  wire logic [6:0]                   nvm_slave_addr_i,
  input  wire logic [7:0]                   nvm_rdata_i,
  output logic                              nvm_we_o,
  output logic [5:0]                        nvm_addr_o,
  output logic [7:0]                        nvm_wdata_o,
  // light meter
  input  wire logic                         meter_done_i,
  input  wire logic [3:0]                   meter_code_i,
  output logic                              meter_en_o,
  output logic                              meter_manual_o,
  output logic [3:0]                        meter_range_o,
  // power control
  output logic [8*pmc_pkg::CFG_BYTES-1:0]   cfg_o,
  output logic                              converter_stop_o,
  output logic                              coldstart_en_o,
  output logic                              lts_protect_o,
  output logic                              soft_reset_o,
  output logic                              spi_selected_o
);
  localparam int CW = $clog2(SETTLE_CYC + 1);
  localparam logic [4:0] IDX_IF  = pmc_pkg::ADR_CFG_END[4:0];
  localparam logic [4:0] IDX_PWR = pmc_pkg::ADR_PWR_MGT[4:0];
  localparam logic [4:0] IDX_LTS = pmc_pkg::ADR_LTS_CFG[4:0];

  if (SETTLE_CYC < 2) begin : g_bad_settle
    $error("settle count must be at least two cycles");
  end

  typedef struct packed {
    logic [7:0]                         sy1;
    logic [7:0]                         sy2;
    logic                               req_d;
    logic                               stop_d;
    logic                               pend;
    logic                               ack_tgl;
    logic [6:0]                         cur;
    logic                               cur_we;
    logic [7:0]                         cur_d;
    logic [7:0]                         rdata;
    logic [7:0]                         key;
    logic [7:0]                         srst;
    logic [pmc_pkg::CFG_BYTES-1:0][7:0] shadow;
    logic [pmc_pkg::CFG_BYTES-1:0][7:0] active;
    logic [6:0]                         lmc;
    logic                               busy;
    logic [3:0]                         result;
    logic [CW-1:0]                      settle;
    logic                               booted;
    logic                               boot2;
    logic                               lts_try;
    logic                               lts_prot;
    logic                               spi_sel;
    logic                               srst_p;
    logic                               nvm_we;
  } pmc_core_t;

  pmc_core_t r;
  pmc_core_t next_r;
  logic      req_ev;
  logic      stop_ev;
  logic      inh;
  logic      sts_low;
  logic      lts_low;

  pmc_acc_if acc ();

  pmc_i2c_slave u_slave (
    .link_clk_i (link_clk_i),
    .nrst_i     (nrst_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .sda_o      (sda_o),
    .sda_oe_o   (sda_oe_o),
    .acc        (acc.link)
  );

  // read mux, no key involved
  function automatic logic [7:0] rd_mux(input pmc_core_t s, input logic [7:0] nv);
    logic [7:0] v;
    v = pmc_pkg::RST_BYTE;
    if (s.cur <= pmc_pkg::ADR_PWR_MGT) begin
      v = s.shadow[s.cur[4:0]];
    end else if (s.cur == pmc_pkg::ADR_SRST) begin
      v = s.srst;
    end else if (s.cur == pmc_pkg::ADR_KEY) begin
      v = s.key;
    end else if (s.cur == pmc_pkg::ADR_LM_CTL) begin
      v = {1'h0, s.lmc};
    end else if (s.cur == pmc_pkg::ADR_LM_OUT) begin
      v = {3'h0, s.busy, s.result};
    end else if (s.cur >= pmc_pkg::ADR_NVM) begin
      v = nv;
    end
    return v;
  endfunction : rd_mux

  assign req_ev  = r.sy2[7] != r.req_d;
  assign stop_ev = r.sy2[6] != r.stop_d;
  assign sts_low = r.sy2[3];
  assign lts_low = r.sy2[2];
  // storage cannot feed the meter
  assign inh = r.sy2[1] | lts_low |
               (r.active[IDX_LTS][pmc_pkg::POS_PRIM] &
                ~r.active[IDX_LTS][pmc_pkg::POS_PRIM_CN]);

  always_comb begin
    next_r        = r;
    next_r.sy1    = {acc.req_tgl, acc.stop_tgl, cs_i, harvest_dis_i, sts_low_i,
                     storage_low_limit_i, storage_disc_i, por_i};
    next_r.sy2    = r.sy1;
    next_r.req_d  = r.sy2[7];
    next_r.stop_d = r.sy2[6];
    next_r.nvm_we = 1'h0;
    next_r.srst_p = 1'h0;
    if (r.sy2[5]) begin
      next_r.spi_sel = 1'h1;
    end
    if (!r.booted) begin
      next_r.booted             = 1'h1;
      next_r.shadow[IDX_IF][6:0] = nvm_slave_addr_i;
      next_r.active[IDX_IF][6:0] = nvm_slave_addr_i;
    end
    // wait one more cycle so the status synchroniser holds the pin level
    if (r.booted) begin
      next_r.boot2 = 1'h1;
    end
    if (r.boot2 && !r.lts_try) begin
      next_r.lts_try = 1'h1;
      if (!r.active[IDX_LTS][pmc_pkg::POS_NO_PROT] && lts_low) begin
        next_r.lts_prot = 1'h1;
      end
    end
    if (r.key != pmc_pkg::KEY_SRST) begin
      next_r.srst = pmc_pkg::RST_BYTE;
    end
    // meter completion
    if (meter_done_i && (r.lmc[pmc_pkg::POS_MEAS] || r.lmc[pmc_pkg::POS_RNG])) begin
      if (!inh) begin
        next_r.result = meter_code_i;
      end
      next_r.busy                 = 1'h0;
      next_r.lmc[pmc_pkg::POS_MEAS] = 1'h0;
    end
    if (req_ev) begin
      next_r.pend   = 1'h1;
      next_r.cur    = acc.addr;
      next_r.cur_we = acc.we;
      next_r.cur_d  = acc.wdata;
    end
    if (r.pend) begin
      next_r.pend    = 1'h0;
      next_r.ack_tgl = ~r.ack_tgl;
      next_r.rdata   = rd_mux(r, nvm_rdata_i);
      if (r.cur_we && r.settle == '0) begin
        if (r.cur <= pmc_pkg::ADR_CFG_END) begin
          if (r.key == pmc_pkg::KEY_CFG) begin
            next_r.shadow[r.cur[4:0]] = r.cur_d;
          end
        end else if (r.cur == pmc_pkg::ADR_PWR_MGT) begin
          next_r.shadow[IDX_PWR] = r.cur_d;
        end else if (r.cur == pmc_pkg::ADR_SRST) begin
          if (r.key == pmc_pkg::KEY_SRST) begin
            next_r.srst = r.cur_d;
          end
        end else if (r.cur == pmc_pkg::ADR_KEY) begin
          next_r.key = r.cur_d;
        end else if (r.cur == pmc_pkg::ADR_LM_CTL) begin
          next_r.lmc[3:0] = r.cur_d[3:0];
          next_r.lmc[pmc_pkg::POS_MANU] = r.cur_d[pmc_pkg::POS_MANU] & ~inh;
          next_r.lmc[pmc_pkg::POS_RNG]  = r.cur_d[pmc_pkg::POS_RNG] & ~inh;
          if (r.cur_d[pmc_pkg::POS_MEAS] && !inh) begin
            next_r.lmc[pmc_pkg::POS_MEAS] = 1'h1;
            next_r.busy                   = 1'h1;
          end
          if (r.cur_d[pmc_pkg::POS_RNG] && !r.lmc[pmc_pkg::POS_RNG] && !inh) begin
            next_r.busy = 1'h1;
          end
          if (!next_r.lmc[pmc_pkg::POS_MEAS] && !next_r.lmc[pmc_pkg::POS_RNG]) begin
            next_r.busy = 1'h0;
          end
        end else if (r.cur >= pmc_pkg::ADR_NVM) begin
          if (r.key == pmc_pkg::KEY_NVM) begin
            next_r.nvm_we = 1'h1;
          end
        end
      end
    end
    // commit after the settling interval
    if (r.settle != '0) begin
      next_r.settle = r.settle - CW'(1);
      if (r.settle == CW'(1)) begin
        next_r.active = r.shadow;
      end
    end
    if (stop_ev) begin
      next_r.key    = pmc_pkg::RST_BYTE;
      next_r.settle = CW'(SETTLE_CYC);
    end
    if (r.srst == pmc_pkg::SRST_WORD) begin
      next_r.srst_p  = 1'h1;
      next_r.key     = pmc_pkg::RST_BYTE;
      next_r.srst    = pmc_pkg::RST_BYTE;
      next_r.shadow  = '0;
      next_r.active  = '0;
      next_r.lmc     = '0;
      next_r.busy    = 1'h0;
      next_r.result  = 4'h0;
      next_r.settle  = '0;
      next_r.booted  = 1'h0;
      next_r.spi_sel = 1'h0;
      next_r.nvm_we  = 1'h0;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign acc.ack_tgl  = r.ack_tgl;
  assign acc.rdata    = r.rdata;
  assign acc.dev_addr = r.active[IDX_IF][6:0];
  assign acc.i2c_en   = ~r.spi_sel;

  assign nvm_we_o       = r.nvm_we;
  assign nvm_addr_o     = r.cur[5:0];
  assign nvm_wdata_o    = r.cur_d;
  assign meter_en_o     = |r.lmc[pmc_pkg::POS_MEAS:pmc_pkg::POS_MANU];
  assign meter_manual_o = r.lmc[pmc_pkg::POS_MANU] &
                          ~(r.lmc[pmc_pkg::POS_MEAS] | r.lmc[pmc_pkg::POS_RNG]);
  assign meter_range_o  = r.lmc[3:0];
  assign cfg_o          = r.active;
  assign converter_stop_o = (r.active[IDX_PWR][pmc_pkg::POS_FORCE] & ~sts_low) |
                            r.sy2[4];
  assign coldstart_en_o = r.sy2[0] | r.lts_prot;
  assign lts_protect_o  = r.lts_prot;
  assign soft_reset_o   = r.srst_p;
  assign spi_selected_o = r.spi_sel;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_meas_end;
    r.busy && meter_done_i && !inh;
  endsequence

  chk_srst_forced_zero: assert property (r.key != pmc_pkg::KEY_SRST |=> r.srst == 8'h00)
    else $error("soft reset word kept without key");
  chk_srst_boot: assert property (r.srst == pmc_pkg::SRST_WORD |=> soft_reset_o ##1 !soft_reset_o)
    else $error("soft reset pulse wrong");
  chk_srst_key_clear: assert property (r.srst == pmc_pkg::SRST_WORD |=> r.key == 8'h00)
    else $error("key survived soft reset");
  chk_stop_key_clear: assert property (stop_ev |=> r.key == 8'h00)
    else $error("key survived transaction end");
  chk_settle_start: assert property (stop_ev && r.srst != pmc_pkg::SRST_WORD
                                     |=> r.settle == CW'(SETTLE_CYC))
    else $error("settle interval not started");
  chk_commit_end: assert property (r.settle == CW'(1) && r.srst != pmc_pkg::SRST_WORD
                                   |=> r.active == $past(r.shadow))
    else $error("configuration not committed");
  chk_cfg_locked: assert property (r.pend && r.cur_we && r.cur <= pmc_pkg::ADR_CFG_END &&
                                   r.key != pmc_pkg::KEY_CFG && r.booted &&
                                   r.srst != pmc_pkg::SRST_WORD |=> $stable(r.shadow))
    else $error("protected register written without key");
  chk_meas_result: assert property (s_meas_end |=> !r.busy && r.result == $past(meter_code_i))
    else $error("busy and result not updated together");
  chk_oneshot_end: assert property (s_meas_end ##0 r.lmc[pmc_pkg::POS_MEAS]
                                    |=> !r.lmc[pmc_pkg::POS_MEAS] && !meter_manual_o[*1])
    else $error("auto measure did not stop");
  chk_nvm_key: assert property (nvm_we_o |-> $past(r.key) == pmc_pkg::KEY_NVM)
    else $error("memory write without key");
endmodule : pmc_regs
`default_nettype wire

// File: tb/pmc_i2c_master.sv
// pmc_i2c_master: behavioural serial master, open-drain data line
// assumes a pull-up resolves sda in the bench
`default_nettype none
module pmc_i2c_master (
  // pins
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 650;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // start or repeated start
  task start;
    #Q sda_low_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_low_o = 1'b1;
    #Q scl_o = 1'b0;
  endtask : start
  task stop;
    #Q sda_low_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_low_o = 1'b0;
    #Q;
  endtask : stop
  task bit_io(input logic b, output logic s);
    #Q sda_low_o = ~b;
    #Q scl_o = 1'b1;
    #Q s = sda_i;
    #Q scl_o = 1'b0;
  endtask : bit_io
  task wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask : wr
  task rd(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(ack, s);
  endtask : rd
endmodule : pmc_i2c_master
`default_nettype wire

// File: tb/pmu_control_regs_i2c_slave_tb.sv
// pmu_control_regs_i2c_slave_tb: self-checking bench of the register block
// assumes the serial master model on the link and a pull-up on sda
`default_nettype none
module pmu_control_regs_i2c_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] SLV = 7'h2c;
  logic mclk_i = 0, link_clk_i = 0, nrst_i = 0, cs_i = 0, meter_done_i = 0;
  logic harvest_dis_i = 0, sts_low_i = 0, storage_low_limit_i = 0;
  logic storage_disc_i = 0, por_i = 0, scl, m_low, a;
  logic [3:0] meter_code_i = 4'h0;
  logic [7:0] nvm_last = 8'h00, b0, b1, k, ad, dt, ex;
  logic sda_oe_o, nvm_we_o, meter_en_o, meter_manual_o, converter_stop_o;
  logic coldstart_en_o, lts_protect_o, soft_reset_o, spi_selected_o;
  logic [5:0] nvm_addr_o;
  logic [7:0] nvm_wdata_o;
  logic [3:0] meter_range_o;
  logic [207:0] cfg_o;
  wire logic sda_w = ~(m_low | sda_oe_o);
  int err_total = 0, check_count = 0, srst_n = 0;
  logic [31:0] rows [4] = '{32'h4b05_0c0c, 32'h0007_3300, 32'h0019_8080, 32'ha545_7777};
  always #5 mclk_i = ~mclk_i;
  always #62.5 link_clk_i = ~link_clk_i;
  pmc_i2c_master mst (.sda_i(sda_w), .scl_o(scl), .sda_low_o(m_low));
  pmc_regs #(.SETTLE_CYC(20)) dut (.mclk_i, .link_clk_i, .nrst_i, .scl_i(scl),
    .sda_i(sda_w), .sda_o(), .sda_oe_o, .cs_i, .harvest_dis_i, .sts_low_i,
    .storage_low_limit_i, .storage_disc_i, .por_i, .nvm_slave_addr_i(SLV),
    .nvm_rdata_i(8'h00), .nvm_we_o, .nvm_addr_o, .nvm_wdata_o, .meter_done_i,
    .meter_code_i, .meter_en_o, .meter_manual_o, .meter_range_o, .cfg_o,
    .converter_stop_o, .coldstart_en_o, .lts_protect_o, .soft_reset_o, .spi_selected_o);
  always @(posedge mclk_i) begin
    if (nvm_we_o === 1'b1) nvm_last <= nvm_wdata_o;
    if (soft_reset_o === 1'b1) srst_n <= srst_n + 1;
  end
  task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task put(input logic [6:0] p, input logic [7:0] d);
    mst.start();
    mst.wr({SLV, 1'b0}, a);
    chk("addr ack", 8'(a), 8'h00);
    mst.wr({1'b0, p}, a);
    mst.wr(d, a);
  endtask : put
  task get(input logic [6:0] p);
    mst.start();
    mst.wr({SLV, 1'b0}, a);
    mst.wr({1'b0, p}, a);
    mst.start();
    mst.wr({SLV, 1'b1}, a);
    mst.rd(1'b0, b0);
    mst.rd(1'b1, b1);
  endtask : get
  task fin;
    mst.stop();
    repeat (40) @(posedge mclk_i);
  endtask : fin
  task pins(input logic [4:0] v);
    @(posedge mclk_i);
    {harvest_dis_i, sts_low_i, storage_disc_i, por_i, storage_low_limit_i} <= v;
    repeat (8) @(posedge mclk_i);
  endtask : pins
  task close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  initial begin
    #3ms;
    err_total++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    nrst_i <= 1'b1;
    #1us;
    get(7'h1a);
    fin();
    chk("word reset", b0, 8'h00);
    chk("key reset", b1, 8'h00);
    foreach (rows[i]) begin
      {k, ad, dt, ex} = rows[i];
      if (k != 8'h00) put(7'h1b, k);
      put(ad[6:0], dt);
      if (ad < 8'h40) chk("cfg early", cfg_o[8*ad +: 8], 8'h00);
      fin();
      chk("row", ad < 8'h40 ? cfg_o[8*ad +: 8] : nvm_last, ex);
    end
    get(7'h18);
    fin();
    chk("addr field", b0, {1'b0, SLV});
    chk("pwr byte", b1, 8'h80);
    chk("conv stop", 8'(converter_stop_o), 8'h01);
    pins(5'b01000);
    chk("conv restart", 8'(converter_stop_o), 8'h00);
    pins(5'b11010);
    chk("harvest off", 8'(converter_stop_o), 8'h01);
    chk("cold start", 8'(coldstart_en_o), 8'h01);
    pins(5'b00100);
    put(7'h1c, 8'h40);
    chk("inhibit", 8'(meter_en_o), 8'h00);
    fin();
    pins(5'b00000);
    put(7'h1c, 8'h40);
    chk("meter on", 8'(meter_en_o), 8'h01);
    get(7'h1d);
    fin();
    chk("busy", b0, 8'h10);
    @(posedge mclk_i) {meter_done_i, meter_code_i} <= 5'h19;
    @(posedge mclk_i) meter_done_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk("meter off", 8'(meter_en_o), 8'h00);
    get(7'h1c);
    fin();
    chk("start bit", b0, 8'h00);
    chk("result", b1, 8'h09);
    put(7'h1c, 8'h1f);
    fin();
    chk("manual", 8'(meter_manual_o), 8'h01);
    chk("range", 8'(meter_range_o), 8'h0f);
    mst.start();
    mst.wr({7'h2d, 1'b0}, a);
    fin();
    chk("foreign addr", 8'(a), 8'h01);
    put(7'h1b, 8'he2);
    put(7'h1a, 8'hab);
    fin();
    chk("soft reset", srst_n[7:0], 8'h01);
    chk("cfg cleared", cfg_o[200 +: 8], 8'h00);
    chk("meter cleared", 8'(meter_manual_o), 8'h00);
    put(7'h1a, 8'hab);
    fin();
    chk("no rekey", srst_n[7:0], 8'h01);
    chk("no protect", 8'(lts_protect_o), 8'h00);
    chk("i2c default", 8'(spi_selected_o), 8'h00);
    @(posedge mclk_i) {storage_low_limit_i, cs_i} <= 2'b11;
    @(posedge mclk_i) nrst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk("reset oe", 8'(sda_oe_o), 8'h00);
    nrst_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    chk("lts protect", 8'(lts_protect_o), 8'h01);
    chk("lts cold", 8'(coldstart_en_o), 8'h01);
    chk("spi select", 8'(spi_selected_o), 8'h01);
    close_out();
  end
endmodule : pmu_control_regs_i2c_slave_tb
`default_nettype wire
